// ---- logic/ospt_channel.v ----
// One-shot and PWM timer channel with counter, reload and output pin
`timescale 1ns/1ps
`default_nettype none
`include "ospt_defs.vh"
module ospt_channel (
  input wire clk,
  input wire rstn,
  input wire sub_clk_tick,
  input wire [1:0] mode,
  input wire [1:0] src_sel,
  input wire [1:0] trig_sel,
  input wire [1:0] ovf_sel,
  input wire pwm8_sel,
  input wire out_enable,
  input wire run_flag,
  input wire oneshot_start,
  input wire timer_wr,
  input wire [15:0] timer_wdata,
  input wire irq_clear,
  input wire timer_trigger_input_pin,
  input wire second_b_group_timer,
  input wire lower_neighbour_channel,
  input wire upper_neighbour_channel,
  output reg [15:0] timer_rdata,
  output reg irq_request,
  output reg timer_pulse_output_pin,
  output reg underflow_pulse
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_COUNT = 4'b0010;
  localparam ST_HIGH = 4'b0100;
  localparam ST_LOW = 4'b1000;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [15:0] reload_r;
  reg [15:0] count_r;
  reg [15:0] count_nxt;
  reg [7:0] pre_r;
  reg [7:0] pre_nxt;
  reg out_nxt;
  reg irq_set;
  reg [1:0] mode_prev_r;
  reg mode_seen_r;
  reg trig_pend_r;
  reg retrig_r;
  reg run_prev_r;
  reg in_s1_r, in_s2_r, in_s3_r;
  reg b2_s1_r, b2_s2_r, b2_s3_r;
  reg lo_s1_r, lo_s2_r, lo_s3_r;
  reg up_s1_r, up_s2_r, up_s3_r;
  wire src_pulse;
  wire ext_rise;
  wire ext_fall;
  wire ovf_evt;
  wire trig_evt;
  wire active_mode;
  wire [7:0] m_val;
  wire [7:0] n_val;

  ospt_prescaler u_pre (
    .clk(clk),
    .rstn(rstn),
    .sub_clk_tick(sub_clk_tick),
    .src_sel(src_sel),
    .src_pulse(src_pulse)
  );

  // Edge detection on a rising 0->1 of a synchronised level
  function is_rise;
    input cur;
    input prev;
    begin
      is_rise = cur & ~prev;
    end
  endfunction

  // Pins cross two flops before any edge logic looks at them
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_s1_r <= 1'b0; in_s2_r <= 1'b0; in_s3_r <= 1'b0;
      b2_s1_r <= 1'b0; b2_s2_r <= 1'b0; b2_s3_r <= 1'b0;
      lo_s1_r <= 1'b0; lo_s2_r <= 1'b0; lo_s3_r <= 1'b0;
      up_s1_r <= 1'b0; up_s2_r <= 1'b0; up_s3_r <= 1'b0;
    end else begin
      in_s1_r <= timer_trigger_input_pin; in_s2_r <= in_s1_r; in_s3_r <= in_s2_r;
      b2_s1_r <= second_b_group_timer; b2_s2_r <= b2_s1_r; b2_s3_r <= b2_s2_r;
      lo_s1_r <= lower_neighbour_channel; lo_s2_r <= lo_s1_r; lo_s3_r <= lo_s2_r;
      up_s1_r <= upper_neighbour_channel; up_s2_r <= up_s1_r; up_s3_r <= up_s2_r;
    end
  end

  assign ext_rise = is_rise(in_s2_r, in_s3_r);
  assign ext_fall = is_rise(in_s3_r, in_s2_r);
  assign ovf_evt = (ovf_sel == `OSPT_OVF_B2) ? is_rise(b2_s2_r, b2_s3_r) :
                   (ovf_sel == `OSPT_OVF_LOWER) ? is_rise(lo_s2_r, lo_s3_r) :
                   is_rise(up_s2_r, up_s3_r); // RULE6
  assign trig_evt = (trig_sel == `OSPT_TRG_SOFT) ? (oneshot_start && mode == `OSPT_MODE_ONESHOT) :
                    (trig_sel == `OSPT_TRG_FALL) ? ext_fall :
                    (trig_sel == `OSPT_TRG_RISE) ? ext_rise : ovf_evt; // RULE5 RULE1
  assign active_mode = (mode == `OSPT_MODE_ONESHOT) || (mode == `OSPT_MODE_PWM);
  assign m_val = reload_r[7:0]; // RULE23
  assign n_val = reload_r[15:8]; // RULE23

  always @* begin
    state_nxt = state_r;
    count_nxt = count_r;
    pre_nxt = pre_r;
    out_nxt = timer_pulse_output_pin;
    irq_set = 1'b0;
    if (!active_mode || !run_flag) begin
      if (run_prev_r && state_r != ST_IDLE && active_mode) begin
        if (mode == `OSPT_MODE_ONESHOT) begin
          irq_set = 1'b1; // RULE4
          count_nxt = reload_r; // RULE4
        end else if (timer_pulse_output_pin) begin
          irq_set = 1'b1; // RULE12
        end
      end
      state_nxt = ST_IDLE;
      out_nxt = 1'b0; // RULE24 RULE4 RULE12
      if (timer_wr)
        count_nxt = timer_wdata; // RULE14
    end else if (!out_enable) begin
      out_nxt = 1'b0; // RULE24
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (trig_pend_r && src_pulse) begin // RULE17
            if (mode == `OSPT_MODE_ONESHOT) begin
              state_nxt = ST_COUNT;
              count_nxt = reload_r;
              out_nxt = 1'b1; // RULE1
            end else if (pwm8_sel ? (n_val != 8'h00) : (reload_r != 16'h0000)) begin
              // RULE9 RULE10 zero disables
              state_nxt = pwm8_sel ? ST_LOW : ST_HIGH;
              count_nxt = pwm8_sel ? {8'h00, n_val} : reload_r;
              pre_nxt = m_val;
              out_nxt = ~pwm8_sel; // RULE7 RULE11
            end
          end
        end
        ST_COUNT: begin
          if (src_pulse) begin
            if (retrig_r) begin
              count_nxt = reload_r; // RULE3 RULE20
            end else if (count_r == 16'h0001 || count_r == 16'h0000) begin
              count_nxt = reload_r; // RULE2
              state_nxt = ST_IDLE;
              out_nxt = 1'b0; // RULE2
              irq_set = 1'b1; // RULE2
            end else begin
              count_nxt = count_r - 16'h0001;
            end
          end
        end
        default: begin
          if (src_pulse) begin
            if (pwm8_sel && pre_r != 8'h00) begin
              pre_nxt = pre_r - 8'h01;
            end else begin
              pre_nxt = m_val; // RULE10
              if (count_r > 16'h0001) begin
                count_nxt = count_r - 16'h0001;
              end else if (state_r == ST_HIGH) begin
                state_nxt = ST_LOW;
                out_nxt = 1'b0; // RULE7
                irq_set = 1'b1; // RULE7
                count_nxt = pwm8_sel ? {8'h00, `OSPT_PWM8_STEPS - n_val} :
                            (`OSPT_PWM16_PERIOD - reload_r); // RULE9 RULE10
              end else begin
                state_nxt = ST_HIGH;
                out_nxt = 1'b1;
                count_nxt = pwm8_sel ? {8'h00, n_val} : reload_r; // RULE8
              end
              if (count_r <= 16'h0001 && state_r == ST_LOW &&
                  (pwm8_sel ? (n_val == 8'h00) : (reload_r == 16'h0000))) begin
                state_nxt = ST_IDLE;
                out_nxt = 1'b0; // RULE9
              end
            end
          end
        end
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      count_r <= `OSPT_TIMER_RESET;
      reload_r <= `OSPT_TIMER_RESET;
      pre_r <= 8'h00;
      timer_pulse_output_pin <= 1'b0;
      run_prev_r <= 1'b0; // RULE16
      trig_pend_r <= 1'b0;
      retrig_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      pre_r <= pre_nxt;
      timer_pulse_output_pin <= out_nxt;
      run_prev_r <= run_flag && active_mode;
      if (timer_wr)
        reload_r <= timer_wdata;
      // Trigger waits for the next count-source pulse
      if (!run_flag || !active_mode || state_r != ST_IDLE)
        trig_pend_r <= 1'b0;
      else if (trig_evt)
        trig_pend_r <= 1'b1; // RULE17
      if (state_r == ST_COUNT && trig_evt)
        retrig_r <= 1'b1; // RULE3
      else if (src_pulse || state_r != ST_COUNT)
        retrig_r <= 1'b0; // RULE20
    end
  end

  // Mode entry request from reset, timer or event-counter mode
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_prev_r <= `OSPT_MODE_TIMER;
      mode_seen_r <= 1'b0;
      irq_request <= 1'b0;
    end else begin
      mode_prev_r <= mode;
      mode_seen_r <= 1'b1;
      if (irq_set ||
          (active_mode && (!mode_seen_r || mode_prev_r == `OSPT_MODE_TIMER ||
                           mode_prev_r == `OSPT_MODE_EVENT))) // RULE18 RULE19
        irq_request <= 1'b1;
      else if (irq_clear)
        irq_request <= 1'b0;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_rdata <= `OSPT_TIMER_RESET;
      underflow_pulse <= 1'b0;
    end else begin
      underflow_pulse <= irq_set && state_r == ST_COUNT;
      // Reload instant reads as all ones, as after an underflow
      if (state_r == ST_COUNT && src_pulse && count_r <= 16'h0001 && !retrig_r)
        timer_rdata <= 16'hFFFF; // RULE13
      else
        timer_rdata <= count_nxt; // RULE13 RULE14
    end
  end
endmodule // ospt_channel
`default_nettype wire

// ---- logic/ospt_defs.vh ----
// Constants for the one-shot / PWM timer channel
// Function
// RULE1: Software start with run flag starts count
// RULE2: Zero count: output low, reload, stop, request
// RULE3: Retrigger reloads at next count pulse
// RULE4: Run cleared: stop, reload, output low, request
// RULE5: Start source: falling, rising, overflow, software
// RULE6: Overflow from B-group timer or neighbours
// RULE7: PWM trigger starts count, output high
// RULE8: PWM reloads each cycle automatically
// RULE9: 16-bit PWM period 65535, high n
// RULE10: 8-bit PWM period (m+1)*255, high n*(m+1)
// RULE11: 8-bit PWM first stays low one width
// RULE12: PWM stop: high goes low with request
// RULE13: Read returns live count, all ones reload
// RULE14: Read after halted write returns written value
// RULE15: Software rewrites timer after free-run stop
// RULE16: Reset clears run; load before run
// RULE17: One-shot output synchronised to count source
// RULE18: Entering one-shot mode sets request; code sets it only when entered from reset, timer or event-counter mode
// RULE19: Entering PWM mode sets request; code sets it only when entered from reset, timer or event-counter mode
// RULE20: Retrigger does one more count; spacing
// RULE21: Count source f1, f8, f32 or secondary
// RULE22: Dividers 1, 8, 32; secondary by 32
// RULE23: 8-bit PWM: low byte m, high byte n
// RULE24: Output low unless running with output on
`ifndef OSPT_DEFS_VH
`define OSPT_DEFS_VH
`define OSPT_MODE_TIMER 2'h0
`define OSPT_MODE_EVENT 2'h1
`define OSPT_MODE_ONESHOT 2'h2
`define OSPT_MODE_PWM 2'h3
`define OSPT_SRC_F1 2'h0
`define OSPT_SRC_F8 2'h1
`define OSPT_SRC_F32 2'h2
`define OSPT_SRC_SECONDARY_CLOCK_DIV32 2'h3
`define OSPT_TRG_SOFT 2'h0
`define OSPT_TRG_FALL 2'h1
`define OSPT_TRG_RISE 2'h2
`define OSPT_TRG_OVF 2'h3
`define OSPT_OVF_B2 2'h0
`define OSPT_OVF_LOWER 2'h1
`define OSPT_OVF_UPPER 2'h2
`define OSPT_DIV8_MAX 5'h07
`define OSPT_DIV32_MAX 5'h1F
`define OSPT_PWM16_PERIOD 16'hFFFF
`define OSPT_PWM8_STEPS 8'hFF
`define OSPT_TIMER_RESET 16'h0000
`endif

// ---- logic/ospt_prescaler.v ----
// Count-source pulse generator: main clock dividers and secondary divider
`timescale 1ns/1ps
`default_nettype none
`include "ospt_defs.vh"
module ospt_prescaler (
  input wire clk,
  input wire rstn,
  input wire sub_clk_tick,
  input wire [1:0] src_sel,
  output reg src_pulse
);
  reg [4:0] main_cnt_r;
  reg [4:0] sub_cnt_r;
  reg pulse_nxt;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_cnt_r <= 5'h00;
      sub_cnt_r <= 5'h00;
    end else begin
      main_cnt_r <= main_cnt_r + 5'h01;
      if (sub_clk_tick)
        sub_cnt_r <= sub_cnt_r + 5'h01;
    end
  end

  always @* begin
    case (src_sel)
      `OSPT_SRC_F1: pulse_nxt = 1'b1; // RULE22
      `OSPT_SRC_F8: pulse_nxt = (main_cnt_r[2:0] == `OSPT_DIV8_MAX); // RULE22
      `OSPT_SRC_F32: pulse_nxt = (main_cnt_r == `OSPT_DIV32_MAX); // RULE22
      default: pulse_nxt = sub_clk_tick && (sub_cnt_r == `OSPT_DIV32_MAX); // RULE22
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      src_pulse <= 1'b0;
    else
      src_pulse <= pulse_nxt; // RULE21
  end
endmodule // ospt_prescaler
`default_nettype wire

// ---- test/ospt_channel_tb_top.sv ----
// Self-checking bench for the one-shot / PWM timer channel
`timescale 1ns/1ps
`default_nettype none
module ospt_channel_tb_top;
  logic clk = 1'h0, rstn = 1'h0, tick = 1'h0, pwm8 = 1'h0, oe = 1'h1, run = 1'h0;
  logic start = 1'h0, wr = 1'h0, clr = 1'h0, tog = 1'h0;
  logic [1:0] mode = 2'h0, src = 2'h0, tsel = 2'h0, osel = 2'h0, div = 2'h0;
  logic [2:0] ovf = 3'h0;
  logic [15:0] wdata = 16'h0000;
  wire [15:0] rdata;
  wire irq, pin, uf, tpin;
  wire [17:0] hi, lo;
  int errors = 0, num_checks = 0, n;
  always #5 clk = ~clk;
  always @(negedge clk) begin
    div <= div + 2'h1;
    tick <= (div == 2'h0);
  end
  ospt_channel ospt_channel_i (.clk(clk), .rstn(rstn), .sub_clk_tick(tick), .mode(mode),
    .src_sel(src), .trig_sel(tsel), .ovf_sel(osel), .pwm8_sel(pwm8), .out_enable(oe),
    .run_flag(run), .oneshot_start(start), .timer_wr(wr), .timer_wdata(wdata), .irq_clear(clr),
    .timer_trigger_input_pin(tpin), .second_b_group_timer(ovf[0]),
    .lower_neighbour_channel(ovf[1]), .upper_neighbour_channel(ovf[2]), .timer_rdata(rdata),
    .irq_request(irq), .timer_pulse_output_pin(pin), .underflow_pulse(uf));
  ospt_far_end ospt_far_end_i (.clk(clk), .toggle_req(tog), .load_pin(pin), .trig_pin(tpin),
    .hi_len(hi), .lo_len(lo));
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_pin(input logic lv, input int lim);
    n = 0;
    while (pin !== lv && n < lim) begin
      step(1);
      n++;
    end
    chk("pin", lv, pin);
  endtask
  task automatic setup(input logic [1:0] md, input logic [1:0] ts, input logic [15:0] v);
    step(1);
    run = 1'h0;
    mode = md;
    tsel = ts;
    wdata = v;
    wr = 1'h1;
    step(1);
    wr = 1'h0;
    clr = 1'h1;
    step(1);
    clr = 1'h0;
    // Two halted cycles so the written value is read back
    step(1);
    run = 1'h1;
  endtask
  task automatic trig_edge(input logic lv);
    repeat ((tpin === lv) ? 2 : 1) begin
      tog = 1'h1;
      step(1);
      tog = 1'h0;
      step(3);
    end
  endtask
  task automatic soft_start;
    start = 1'h1;
    step(1);
    start = 1'h0;
  endtask
  task automatic t_entry;
    chk("reset read", 16'h0000, rdata);
    mode = 2'h2;
    step(3);
    chk("oneshot entry", 1'h1, irq);
    clr = 1'h1;
    mode = 2'h0;
    step(1);
    clr = 1'h0;
    mode = 2'h3;
    step(3);
    chk("pwm entry", 1'h1, irq);
    $display("test mode entry done");
  endtask
  task automatic t_oneshot(input logic [1:0] sr, input logic [15:0] exp);
    src = sr;
    setup(2'h2, 2'h0, 16'h0003);
    step(2);
    chk("halted read", 16'h0003, rdata);
    soft_start();
    wait_pin(1'h1, 200);
    wait_pin(1'h0, 600);
    step(2);
    chk("width", exp, hi);
    chk("end irq", 1'h1, irq);
    chk("reload", 16'h0003, rdata);
    $display("test one-shot source done");
  endtask
  task automatic t_stop_retrig;
    src = 2'h0;
    setup(2'h2, 2'h0, 16'h0032);
    soft_start();
    wait_pin(1'h1, 10);
    step(5);
    run = 1'h0;
    step(3);
    chk("stop pin", 1'h0, pin);
    chk("stop irq", 1'h1, irq);
    chk("stop reload", 16'h0032, rdata);
    setup(2'h2, 2'h2, 16'h0014);
    trig_edge(1'h1);
    wait_pin(1'h1, 6);
    trig_edge(1'h0);
    trig_edge(1'h1);
    wait_pin(1'h0, 60);
    step(2);
    chk("retrigger", 1'h1, hi >= 28 && hi <= 34);
    $display("test stop and retrigger done");
  endtask
  task automatic t_pwm;
    pwm8 = 1'h1;
    setup(2'h3, 2'h1, 16'h0301);
    trig_edge(1'h0);
    wait_pin(1'h1, 30);
    chk("first low", 1'h1, n >= 4 && n <= 12);
    wait_pin(1'h0, 20);
    step(2);
    chk("pwm8 high", 16'h0006, hi);
    chk("pwm irq", 1'h1, irq);
    wait_pin(1'h1, 600);
    wait_pin(1'h0, 20);
    chk("pwm8 low", 16'h01F8, lo);
    clr = 1'h1;
    step(1);
    clr = 1'h0;
    step(50);
    run = 1'h0;
    step(3);
    chk("quiet stop", 1'h0, irq);
    pwm8 = 1'h0;
    for (int k = 0; k < 3; k++) begin
      osel = k[1:0];
      setup(2'h3, 2'h3, 16'h0005);
      ovf[(k + 1) % 3] = 1'h1;
      step(1);
      ovf = 3'h0;
      step(8);
      chk("other overflow", 1'h0, pin);
      ovf[k] = 1'h1;
      step(1);
      ovf = 3'h0;
      wait_pin(1'h1, 10);
      wait_pin(1'h0, 10);
      step(2);
      chk("pwm16 high", 16'h0005, hi);
    end
    setup(2'h3, 2'h3, 16'h0005);
    ovf[2] = 1'h1;
    step(1);
    ovf = 3'h0;
    wait_pin(1'h1, 10);
    run = 1'h0;
    step(2);
    chk("pwm stop pin", 1'h0, pin);
    chk("pwm stop irq", 1'h1, irq);
    setup(2'h3, 2'h2, 16'h0000);
    trig_edge(1'h1);
    step(40);
    chk("zero duty", 1'h0, pin);
    oe = 1'h0;
    setup(2'h2, 2'h0, 16'h000A);
    soft_start();
    step(5);
    chk("disabled", 1'h0, pin);
    $display("test pwm done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    step(16);
    rstn = 1'h1;
    t_entry();
    t_oneshot(2'h0, 16'h0003);
    t_oneshot(2'h1, 16'h0018);
    t_oneshot(2'h2, 16'h0060);
    t_oneshot(2'h3, 16'h0180);
    t_stop_retrig();
    t_pwm();
    complete_run();
  end
  initial begin
    #300us;
    errors++;
    complete_run();
  end
endmodule // ospt_channel_tb_top
`default_nettype wire

// ---- test/ospt_checker.sv ----
// Assertion checker bound to the timer channel ports
`timescale 1ns/1ps
`default_nettype none
module ospt_checker (
  input wire clk,
  input wire rstn,
  input wire [1:0] mode,
  input wire [1:0] src_sel,
  input wire [1:0] trig_sel,
  input wire out_enable,
  input wire run_flag,
  input wire oneshot_start,
  input wire timer_wr,
  input wire [15:0] timer_wdata,
  input wire irq_clear,
  input wire [15:0] timer_rdata,
  input wire irq_request,
  input wire timer_pulse_output_pin,
  input wire underflow_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_soft_start;
    mode == 2'h2 && trig_sel == 2'h0 && src_sel == 2'h0 && run_flag && out_enable
      && oneshot_start && !timer_pulse_output_pin;
  endsequence
  sequence s_halted_wr;
    !run_flag && timer_wr ##1 (!run_flag && !timer_wr) [*2];
  endsequence
  a_soft_start_high: assert property (s_soft_start |-> ##[1:4] timer_pulse_output_pin)
    else $error("soft start gave no output");
  a_end_sets_irq: assert property ($fell(timer_pulse_output_pin) && mode == 2'h2
    && out_enable && $past(out_enable) && !irq_clear |-> ##[0:1] irq_request)
    else $error("one-shot end without request");
  a_underflow_low: assert property (underflow_pulse |-> ##[0:1] !timer_pulse_output_pin)
    else $error("output high at count end");
  a_run_stop_irq: assert property (mode[1] && out_enable && timer_pulse_output_pin
    && $fell(run_flag) |-> ##[0:2] (!timer_pulse_output_pin && irq_request))
    else $error("stop while high mishandled");
  a_pwm_quiet_stop: assert property (mode == 2'h3 && $stable(mode) && $fell(run_flag)
    && !timer_pulse_output_pin && !irq_request |=> !irq_request [*2])
    else $error("stop while low raised request");
  a_mode_entry_irq: assert property (mode[1] && !$past(mode[1]) |-> ##[0:2] irq_request)
    else $error("mode entry without request");
  a_disabled_low: assert property ((!out_enable) [*2] |-> !timer_pulse_output_pin)
    else $error("output high while disabled");
  a_idle_mode_low: assert property ((!mode[1]) [*2] |-> !timer_pulse_output_pin)
    else $error("output high in counting modes");
  a_halted_read: assert property (s_halted_wr |-> timer_rdata == $past(timer_wdata, 2))
    else $error("halted write not read back");
  a_underflow_flag: assert property ($fell(timer_pulse_output_pin) && mode == 2'h2
    && $stable(mode) && run_flag && $past(run_flag) && out_enable && $past(out_enable)
    |-> underflow_pulse)
    else $error("one-shot end without underflow pulse");
  a_reload_ones: assert property (underflow_pulse && $past(run_flag) |-> timer_rdata == 16'hFFFF)
    else $error("reload instant did not read all ones");
endmodule // ospt_checker
bind ospt_channel ospt_checker ospt_checker_i (.clk(clk), .rstn(rstn), .mode(mode),
  .src_sel(src_sel), .trig_sel(trig_sel), .out_enable(out_enable), .run_flag(run_flag),
  .oneshot_start(oneshot_start), .timer_wr(timer_wr), .timer_wdata(timer_wdata),
  .irq_clear(irq_clear), .timer_rdata(timer_rdata), .irq_request(irq_request),
  .timer_pulse_output_pin(timer_pulse_output_pin), .underflow_pulse(underflow_pulse));
`default_nettype wire

// ---- test/ospt_far_end.sv ----
// Far-side model: drives the trigger pin and times the load on the output pin
`timescale 1ns/1ps
`default_nettype none
module ospt_far_end (
  input wire logic clk,
  input wire logic toggle_req,
  input wire logic load_pin,
  output var logic trig_pin,
  output var logic [17:0] hi_len,
  output var logic [17:0] lo_len
);
  logic [17:0] run_r = 18'h0_0000;
  logic [3:0] gap_r = 4'h0;
  logic prev_r = 1'h0;
  initial begin
    trig_pin = 1'h0;
    hi_len = 18'h0_0000;
    lo_len = 18'h0_0000;
  end
  always @(posedge clk) begin
    prev_r <= load_pin;
    run_r <= (load_pin == prev_r) ? run_r + 18'h0_0001 : 18'h0_0001;
    if (load_pin != prev_r && prev_r) hi_len <= run_r;
    if (load_pin != prev_r && !prev_r) lo_len <= run_r;
    // Closer edges would fall inside one count source cycle
    if (toggle_req && gap_r >= 4'h3) begin
      trig_pin <= ~trig_pin;
      gap_r <= 4'h0;
    end else if (gap_r != 4'hF) begin
      gap_r <= gap_r + 4'h1;
    end
  end
endmodule // ospt_far_end
`default_nettype wire
